// ===== hw/gpio_port_block.sv
// gpio_port_block: one eight-bit general-purpose port with register access,
// pin interrupts, alternate function muxing and pad configuration.
// assumes pad_in is asynchronous, the alternate peripheral runs on ref_clk,
// and the system holds eight copies with their own reset parameters.
`timescale 1ns/10ps
`default_nettype none
module gpio_port_block
   import gpio_port_pkg::*;
#(
   parameter logic [7:0] DEBUG_PINS = 8'h00,
   parameter logic [7:0] CONNECTED  = 8'hFF
)
(
   input  wire logic                   ref_clk,
   input  wire logic                   rst_n,
   input  wire gpio_port_pkg::bus_req_t bus_req,
   output var  logic [31:0]            rdata,
   input  wire logic [7:0]             pad_in,
   output var  logic [7:0]             pad_out,
   output var  logic [7:0]             pad_oe,
   output var  gpio_port_pkg::pad_cfg_t pad_cfg,
   input  wire logic [7:0]             alt_out,
   input  wire logic [7:0]             alt_oe,
   output var  logic [7:0]             alt_in,
   output var  logic                   port_irq
);
   import gpio_port_pkg::*;

   logic [7:0]  pin_direction;
   logic [7:0]  pin_data;
   logic [7:0]  irq_sense_select;
   logic [7:0]  irq_both_edges;
   logic [7:0]  irq_event_polarity;
   logic [7:0]  irq_mask;
   logic [7:0]  edge_latch;
   logic [7:0]  irq_raw_status;
   logic [7:0]  irq_masked_status;
   logic [7:0]  alt_function_select;
   logic [7:0]  commit_enable;
   logic        unlocked;
   logic [7:0]  sync1;
   logic [7:0]  sync2;
   logic [7:0]  sync3;
   logic [7:0]  pin_level;
   logic [7:0]  pin_prev;
   logic [7:0]  pin_seen;
   logic [7:0]  edge_hit;
   logic [7:0]  level_hit;
   logic [7:0]  next_drive;
   logic [7:0]  next_oe;
   logic [31:0] next_rdata;
   logic [7:0]  wmask;
   logic [7:0]  wbyte;
   logic        data_hit;
   logic [7:0]  addr_mask;

   assign wbyte     = bus_req.wdata[7:0] & CONNECTED;
   assign addr_mask = bus_req.addr[MASK_LSB +: 8];
   assign data_hit  = (bus_req.addr <= DATA_LAST);
   assign wmask     = addr_mask & CONNECTED;

   // three-stage input filter; a change counts when stages 2 and 3 agree
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         sync1     <= RST_ZERO;
         sync2     <= RST_ZERO;
         sync3     <= RST_ZERO;
         pin_level <= RST_ZERO;
         pin_prev  <= RST_ZERO;
      end
      else
      begin
         sync1     <= pad_in;
         sync2     <= sync1;
         sync3     <= sync2;
         pin_level <= (sync2 == sync3) ? sync3 : pin_level;
         pin_prev  <= pin_seen;
      end
   end

   // disabled digital input reads low so a floating pad cannot trigger an edge
   assign pin_seen = pin_level & pad_cfg.digital_en;

   // direction and data register
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         pin_direction <= RST_ZERO;
         pin_data      <= RST_ZERO;
      end
      else
      begin
         if (bus_req.wr && bus_req.addr == OFF_DIR)
            pin_direction <= wbyte;
         for (int i = 0; i < PINS; i++)
         begin
            if (!pin_direction[i])
               pin_data[i] <= pin_seen[i];
            else if (bus_req.wr && data_hit && wmask[i])
               pin_data[i] <= bus_req.wdata[i];
         end
      end
   end

   // interrupt configuration; software masks first
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         irq_sense_select   <= RST_ZERO;
         irq_both_edges     <= RST_ZERO;
         irq_event_polarity <= RST_ZERO;
         irq_mask           <= RST_ZERO;
      end
      else if (bus_req.wr)
      begin
         if (bus_req.addr == OFF_SENSE)
            irq_sense_select <= wbyte;
         if (bus_req.addr == OFF_BOTH)
            irq_both_edges <= wbyte;
         if (bus_req.addr == OFF_EVENT)
            irq_event_polarity <= wbyte;
         if (bus_req.addr == OFF_MASK)
            irq_mask <= wbyte;
      end
   end

   // condition detection per pin
   generate
      for (genvar g = 0; g < PINS; g++)
      begin : g_detect
         logic rise;
         logic fall;
         assign rise = pin_seen[g] & ~pin_prev[g];
         assign fall = ~pin_seen[g] & pin_prev[g];
         assign edge_hit[g] = !irq_sense_select[g] &&
                              (irq_both_edges[g] ? (rise | fall)
                               : (irq_event_polarity[g] ? rise : fall));
         // level is not latched: the source keeps it
         assign level_hit[g] = irq_sense_select[g] &&
                               (pin_seen[g] == irq_event_polarity[g]);
      end
   endgenerate

   // edge latch: a new edge in the clearing cycle wins over the clear
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         edge_latch <= RST_ZERO;
      else
      begin
         for (int i = 0; i < PINS; i++)
         begin
            if (edge_hit[i])
               edge_latch[i] <= 1'b1;
            else if (bus_req.wr && bus_req.addr == OFF_CLEAR && wbyte[i])
               edge_latch[i] <= 1'b0;
            else if (irq_sense_select[i])
               edge_latch[i] <= 1'b0;
         end
      end
   end

   assign irq_raw_status    = (edge_latch | level_hit) & CONNECTED;
   assign irq_masked_status = irq_raw_status & irq_mask;

   // single merged output per port
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         port_irq <= 1'b0;
      else
         port_irq <= |irq_masked_status;
   end

   // lock and commit protection
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         unlocked      <= 1'b0;
         commit_enable <= RST_COMMIT_ALL & ~DEBUG_PINS;
      end
      else if (bus_req.wr)
      begin
         if (bus_req.addr == OFF_LOCK)
            unlocked <= (bus_req.wdata == UNLOCK_KEY);
         // only debug lanes are writable; others stay committable
         if (bus_req.addr == OFF_COMMIT && unlocked)
            commit_enable <= (wbyte & DEBUG_PINS) | (RST_COMMIT_ALL & ~DEBUG_PINS);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         alt_function_select <= DEBUG_PINS;
      else if (bus_req.wr && bus_req.addr == OFF_ALT)
      begin
         for (int i = 0; i < PINS; i++)
         begin
            if (CONNECTED[i] && commit_enable[i] && (unlocked || !DEBUG_PINS[i]))
               alt_function_select[i] <= bus_req.wdata[i];
         end
      end
   end

   // pad controls; drive strengths are mutually exclusive per pin
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         pad_cfg.pull_up    <= DEBUG_PINS;
         pad_cfg.pull_down  <= RST_ZERO;
         pad_cfg.drive_2ma  <= RST_DRV2;
         pad_cfg.drive_4ma  <= RST_ZERO;
         pad_cfg.drive_8ma  <= RST_ZERO;
         pad_cfg.slew       <= RST_ZERO;
         pad_cfg.open_drain <= RST_ZERO;
         pad_cfg.digital_en <= DEBUG_PINS;
      end
      else if (bus_req.wr)
      begin
         unique case (bus_req.addr)
            OFF_DRV2:
            begin
               pad_cfg.drive_2ma <= (pad_cfg.drive_2ma & ~CONNECTED) | wbyte;
               pad_cfg.drive_4ma <= pad_cfg.drive_4ma & ~wbyte;
               pad_cfg.drive_8ma <= pad_cfg.drive_8ma & ~wbyte;
            end
            OFF_DRV4:
            begin
               pad_cfg.drive_4ma <= (pad_cfg.drive_4ma & ~CONNECTED) | wbyte;
               pad_cfg.drive_2ma <= pad_cfg.drive_2ma & ~wbyte;
               pad_cfg.drive_8ma <= pad_cfg.drive_8ma & ~wbyte;
            end
            OFF_DRV8:
            begin
               pad_cfg.drive_8ma <= (pad_cfg.drive_8ma & ~CONNECTED) | wbyte;
               pad_cfg.drive_2ma <= pad_cfg.drive_2ma & ~wbyte;
               pad_cfg.drive_4ma <= pad_cfg.drive_4ma & ~wbyte;
            end
            OFF_OPEN_DRAIN: pad_cfg.open_drain <= wbyte;
            OFF_PULL_UP:
            begin
               pad_cfg.pull_up   <= wbyte;
               pad_cfg.pull_down <= pad_cfg.pull_down & ~wbyte;
            end
            OFF_PULL_DOWN:
            begin
               pad_cfg.pull_down <= wbyte;
               pad_cfg.pull_up   <= pad_cfg.pull_up & ~wbyte;
            end
            // slew only has meaning in 8 mA mode
            OFF_SLEW:       pad_cfg.slew <= wbyte & pad_cfg.drive_8ma;
            OFF_DIG_EN:     pad_cfg.digital_en <= wbyte;
            default:        ;
         endcase
      end
   end

   // pin drive mux; open drain only pulls low
   always_comb
   begin
      for (int i = 0; i < PINS; i++)
      begin
         next_drive[i] = alt_function_select[i] ? alt_out[i] : pin_data[i];
         next_oe[i]    = alt_function_select[i] ? alt_oe[i] : pin_direction[i];
         if (pad_cfg.open_drain[i])
         begin
            next_oe[i]    = next_oe[i] & ~next_drive[i];
            next_drive[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         pad_out <= RST_ZERO;
         pad_oe  <= RST_ZERO;
         alt_in  <= RST_ZERO;
      end
      else
      begin
         pad_out <= next_drive & CONNECTED;
         pad_oe  <= next_oe & CONNECTED;
         alt_in  <= pin_seen & alt_function_select;
      end
   end

   // read path, answer in the next cycle only
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (data_hit)
         next_rdata[7:0] = pin_data & addr_mask;
      else
      begin
         unique case (bus_req.addr)
            OFF_DIR:        next_rdata[7:0] = pin_direction;
            OFF_SENSE:      next_rdata[7:0] = irq_sense_select;
            OFF_BOTH:       next_rdata[7:0] = irq_both_edges;
            OFF_EVENT:      next_rdata[7:0] = irq_event_polarity;
            OFF_MASK:       next_rdata[7:0] = irq_mask;
            OFF_RAW:        next_rdata[7:0] = irq_raw_status;
            OFF_MASKED:     next_rdata[7:0] = irq_masked_status;
            OFF_ALT:        next_rdata[7:0] = alt_function_select;
            OFF_DRV2:       next_rdata[7:0] = pad_cfg.drive_2ma;
            OFF_DRV4:       next_rdata[7:0] = pad_cfg.drive_4ma;
            OFF_DRV8:       next_rdata[7:0] = pad_cfg.drive_8ma;
            OFF_OPEN_DRAIN: next_rdata[7:0] = pad_cfg.open_drain;
            OFF_PULL_UP:    next_rdata[7:0] = pad_cfg.pull_up;
            OFF_PULL_DOWN:  next_rdata[7:0] = pad_cfg.pull_down;
            OFF_SLEW:       next_rdata[7:0] = pad_cfg.slew;
            OFF_DIG_EN:     next_rdata[7:0] = pad_cfg.digital_en;
            OFF_LOCK:       next_rdata[0]   = ~unlocked;
            OFF_COMMIT:     next_rdata[7:0] = commit_enable;
            OFF_PERIPH_ID:  next_rdata      = PERIPH_ID_VAL;
            OFF_CELL_ID:    next_rdata      = CELL_ID_VAL;
            default:        next_rdata      = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         rdata <= 32'h0000_0000;
      else
         rdata <= bus_req.rd ? next_rdata : 32'h0000_0000;
   end

   // ---- checks ----
   // a write that lands in the masked data window
   sequence s_data_write;
      bus_req.wr && data_hit;
   endsequence

   chk_reset_undriven: assert property (@(posedge ref_clk)
      !rst_n |=> (pad_oe == 8'h00 && alt_function_select == DEBUG_PINS && commit_enable == ~DEBUG_PINS))
      else $error("reset values wrong");

   chk_input_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (pin_direction[0] == 1'b0) |=> (pin_data[0] == $past(pin_seen[0])))
      else $error("input bit not captured");

   chk_masked_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (s_data_write ##0 (pin_direction[0] && !addr_mask[0])) |=> (pin_data[0] == $past(pin_data[0])))
      else $error("unmasked data bit changed");

   chk_masked_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (bus_req.rd && data_hit) |=> ((rdata[7:0] & ~$past(addr_mask)) == 8'h00))
      else $error("masked read bit not zero");

   chk_irq_merge: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (|irq_masked_status) |=> port_irq)
      else $error("port interrupt missing");

   chk_edge_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (edge_latch[0] && !irq_sense_select[0] && !(bus_req.wr && bus_req.addr == OFF_CLEAR))
      |=> edge_latch[0])
      else $error("edge latch lost");

   chk_clear_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (bus_req.wr && bus_req.addr == OFF_CLEAR && wbyte[0] && !edge_hit[0]) |=> !edge_latch[0])
      else $error("clear did not clear");

   chk_mask_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (irq_mask == 8'h00) [*2] |-> !port_irq)
      else $error("masked interrupt reached output");

   chk_alt_protect: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (bus_req.wr && bus_req.addr == OFF_ALT) |=>
      (((alt_function_select ^ $past(alt_function_select))
        & ~($past(commit_enable) & ({8{$past(unlocked)}} | ~DEBUG_PINS))) == 8'h00))
      else $error("protected select changed");

   chk_output_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (pin_direction[0] && !alt_function_select[0] && !pad_cfg.open_drain[0] && CONNECTED[0])
      |=> (pad_oe[0] && pad_out[0] == $past(pin_data[0])))
      else $error("output bit not driven");
endmodule
`default_nettype wire

// ===== hw/gpio_port_pkg.sv
// gpio_port_pkg: register map, reset values and carrier types for one gpio port
// assumes byte addresses on a 12-bit register port with 32-bit data
package gpio_port_pkg;
   localparam int          ADDR_W          = 12;
   localparam int          DATA_W          = 32;
   localparam int          PINS            = 8;
   // data register spans 256 words, address bits 9:2 form the bit mask
   localparam logic [11:0] DATA_LAST       = 12'h3FC;
   localparam int          MASK_LSB        = 2;
   localparam logic [11:0] OFF_DIR         = 12'h400;
   localparam logic [11:0] OFF_SENSE       = 12'h404;
   localparam logic [11:0] OFF_BOTH        = 12'h408;
   localparam logic [11:0] OFF_EVENT       = 12'h40C;
   localparam logic [11:0] OFF_MASK        = 12'h410;
   localparam logic [11:0] OFF_RAW         = 12'h414;
   localparam logic [11:0] OFF_MASKED      = 12'h418;
   localparam logic [11:0] OFF_CLEAR       = 12'h41C;
   localparam logic [11:0] OFF_ALT         = 12'h420;
   localparam logic [11:0] OFF_DRV2        = 12'h500;
   localparam logic [11:0] OFF_DRV4        = 12'h504;
   localparam logic [11:0] OFF_DRV8        = 12'h508;
   localparam logic [11:0] OFF_OPEN_DRAIN  = 12'h50C;
   localparam logic [11:0] OFF_PULL_UP     = 12'h510;
   localparam logic [11:0] OFF_PULL_DOWN   = 12'h514;
   localparam logic [11:0] OFF_SLEW        = 12'h518;
   localparam logic [11:0] OFF_DIG_EN      = 12'h51C;
   localparam logic [11:0] OFF_LOCK        = 12'h520;
   localparam logic [11:0] OFF_COMMIT      = 12'h524;
   localparam logic [11:0] OFF_PERIPH_ID   = 12'hFE0;
   localparam logic [11:0] OFF_CELL_ID     = 12'hFF0;
   localparam logic [7:0]  RST_ZERO        = 8'h00;
   localparam logic [7:0]  RST_DRV2        = 8'hFF;
   localparam logic [7:0]  RST_COMMIT_ALL  = 8'hFF;
   // value arbitrary
   localparam logic [31:0] UNLOCK_KEY      = 32'h1ACC_E55A;
   // identification values arbitrary
   localparam logic [31:0] PERIPH_ID_VAL   = 32'h0000_0061;
   localparam logic [31:0] CELL_ID_VAL     = 32'h0000_00C5;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_t;

   typedef struct packed {
      logic [7:0] pull_up;
      logic [7:0] pull_down;
      logic [7:0] drive_2ma;
      logic [7:0] drive_4ma;
      logic [7:0] drive_8ma;
      logic [7:0] slew;
      logic [7:0] open_drain;
      logic [7:0] digital_en;
   } pad_cfg_t;
endpackage

// ===== testbench/gpio_pin_partner.sv
// gpio_pin_partner: pins and alternate peripheral facing one gpio port
// assumes the bench sets the external levels and the peripheral's wishes
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_partner
   import gpio_port_pkg::*;
(
   input  wire logic                    ref_clk,
   input  wire logic [7:0]              pad_out,
   input  wire logic [7:0]              pad_oe,
   input  wire gpio_port_pkg::pad_cfg_t pad_cfg,
   input  wire logic [7:0]              ext_level,
   input  wire logic [7:0]              ext_drive,
   input  wire logic [7:0]              periph_out,
   input  wire logic [7:0]              periph_oe,
   output var  logic [7:0]              pad_in,
   output var  logic [7:0]              alt_out,
   output var  logic [7:0]              alt_oe
);
   import gpio_port_pkg::*;

   logic toggle = 1'b0;

   // a floating pin must not look like a stable level
   always_ff @(posedge ref_clk)
   begin
      toggle <= ~toggle;
   end

   // peripheral lives on the same clock
   always_ff @(posedge ref_clk)
   begin
      alt_out <= periph_out;
      alt_oe  <= periph_oe;
   end

   // external levels held steady by the bench until recognised
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (pad_oe[i])
            pad_in[i] = pad_out[i];
         else if (ext_drive[i])
            pad_in[i] = ext_level[i];
         else if (pad_cfg.pull_up[i])
            pad_in[i] = 1'b1;
         else if (pad_cfg.pull_down[i])
            pad_in[i] = 1'b0;
         else
            pad_in[i] = toggle;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/gpio_port_block_tb.sv
// gpio_port_block_tb: register-level checks of one gpio port with a debug pin on lane 7
// assumes lane 6 is unconnected, so its reads are ignored
`timescale 1ns/10ps
`default_nettype none
module gpio_port_block_tb;
   import gpio_port_pkg::*;
   localparam logic [31:0] MSK = 32'hFFFF_FFBF;
   logic                    ref_clk;
   logic                    rst_n;
   bus_req_t                bus_req;
   logic [31:0]             rdata;
   logic [7:0]              pad_in;
   logic [7:0]              pad_out;
   logic [7:0]              pad_oe;
   pad_cfg_t                pad_cfg;
   logic [7:0]              alt_out;
   logic [7:0]              alt_oe;
   logic [7:0]              alt_in;
   logic                    port_irq;
   logic [7:0]              ext_level;
   logic [7:0]              ext_drive;
   logic [7:0]              periph_out;
   logic [7:0]              periph_oe;
   int                      miscompares;
   int                      checks_done;
   int                      cycles;
   logic [11:0]             rst_addr [13];
   logic [31:0]             rst_val [13];

   gpio_port_block #(.DEBUG_PINS(8'h80), .CONNECTED(8'hBF)) dut (
      .ref_clk (ref_clk), .rst_n (rst_n), .bus_req (bus_req), .rdata (rdata),
      .pad_in (pad_in), .pad_out (pad_out), .pad_oe (pad_oe), .pad_cfg (pad_cfg),
      .alt_out (alt_out), .alt_oe (alt_oe), .alt_in (alt_in), .port_irq (port_irq));

   gpio_pin_partner pins (
      .ref_clk (ref_clk), .pad_out (pad_out), .pad_oe (pad_oe), .pad_cfg (pad_cfg),
      .ext_level (ext_level), .ext_drive (ext_drive), .periph_out (periph_out),
      .periph_oe (periph_oe), .pad_in (pad_in), .alt_out (alt_out), .alt_oe (alt_oe));

   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic close_out();
      $display("compares %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         close_out();
      end
   end

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus_req.wr <= 1'b0;
   endtask

   task automatic reg_chk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
      logic [31:0] got;
      @(posedge ref_clk);
      bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus_req.rd <= 1'b0;
      #1;
      got = rdata;
      checks_done++;
      if ((got & m) !== (exp & m))
      begin
         miscompares++;
         $display("MISMATCH t=%0t addr=%h got=%h exp=%h", $time, a, got, exp & m);
      end
   endtask

   task automatic pin_chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
      checks_done++;
      if ((got & m) !== (exp & m))
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp & m);
      end
   endtask

   // pin inputs pass a three-flop filter before detection and the irq register
   task automatic settle();
      repeat (8) @(posedge ref_clk);
      #1;
   endtask

   initial
   begin
      rst_n = 1'b0;
      bus_req = '0;
      ext_level = 8'h00;
      ext_drive = 8'h00;
      periph_out = 8'h00;
      periph_oe = 8'h00;
      miscompares = 0;
      checks_done = 0;
      cycles = 0;
      rst_addr = '{OFF_ALT, OFF_PULL_UP, OFF_DIG_EN, OFF_DIR, OFF_PULL_DOWN, OFF_DRV2, OFF_DRV4,
                   OFF_COMMIT, OFF_LOCK, OFF_PERIPH_ID, OFF_CELL_ID, OFF_RAW, 12'h600};
      rst_val = '{32'h80, 32'h80, 32'h80, 32'h0, 32'h0, 32'hFF, 32'h0,
                  32'h7F, 32'h1, PERIPH_ID_VAL, CELL_ID_VAL, 32'h0, 32'h0};
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      pin_chk(pad_oe, 8'h00, 8'hFF);
      pin_chk(pad_cfg.pull_up, 8'h80, 8'hBF);
      pin_chk(pad_cfg.digital_en, 8'h80, 8'hBF);
      wr(12'h600, 32'hFF);
      wr(OFF_PERIPH_ID, 32'h0);
      for (int i = 0; i < 13; i++)
         reg_chk(rst_addr[i], rst_val[i], MSK);

      // output path with address-masked access
      wr(OFF_DIG_EN, 32'hFF);
      wr(OFF_DIR, 32'hFF);
      reg_chk(OFF_DIR, 32'hBF, 32'hFF);
      wr(DATA_LAST, 32'h00);
      wr(12'h098, 32'hEB);
      reg_chk(DATA_LAST, 32'h22, 32'h3F);
      reg_chk(12'h0C4, 32'h20, 32'h3F);
      settle();
      pin_chk(pad_out, 8'h22, 8'h3F);
      pin_chk(pad_oe, 8'h3F, 8'hFF);

      // input path and alternate function on the debug lane
      wr(OFF_DIR, 32'h00);
      ext_drive <= 8'hFF;
      ext_level <= 8'hA5;
      periph_oe <= 8'h80;
      periph_out <= 8'h80;
      settle();
      reg_chk(DATA_LAST, 32'h25, 32'h3F);
      pin_chk(alt_in, 8'h80, 8'hFF);
      pin_chk(pad_oe, 8'h80, 8'hFF);
      pin_chk(pad_out, 8'h80, 8'h80);
      periph_oe <= 8'h00;
      periph_out <= 8'h00;

      // commit protection of the debug lane
      wr(OFF_ALT, 32'h01);
      reg_chk(OFF_ALT, 32'h81, MSK);
      wr(OFF_ALT, 32'h00);
      reg_chk(OFF_ALT, 32'h80, MSK);
      wr(OFF_LOCK, UNLOCK_KEY);
      reg_chk(OFF_LOCK, 32'h0, MSK);
      wr(OFF_COMMIT, 32'hFF);
      reg_chk(OFF_COMMIT, 32'hFF, MSK);
      wr(OFF_ALT, 32'h00);
      reg_chk(OFF_ALT, 32'h00, MSK);
      wr(OFF_LOCK, 32'h0);
      wr(OFF_ALT, 32'h80);
      reg_chk(OFF_ALT, 32'h00, MSK);

      // lane 0 rise, 1 fall, 2 both, 3 high, 4 low; masked while set up
      wr(OFF_MASK, 32'h00);
      wr(OFF_SENSE, 32'h18);
      wr(OFF_BOTH, 32'h04);
      wr(OFF_EVENT, 32'h09);
      ext_level <= 8'h00;
      settle();
      wr(OFF_CLEAR, 32'hFF);
      settle();
      reg_chk(OFF_RAW, 32'h10, 32'h1F);
      ext_level <= 8'h0D;
      settle();
      reg_chk(OFF_RAW, 32'h1D, 32'h1F);
      reg_chk(OFF_MASKED, 32'h00, 32'h1F);
      pin_chk({7'h0, port_irq}, 8'h00, 8'h01);
      wr(OFF_MASK, 32'h01);
      settle();
      reg_chk(OFF_MASKED, 32'h01, 32'h1F);
      pin_chk({7'h0, port_irq}, 8'h01, 8'h01);
      ext_level <= 8'h10;
      settle();
      reg_chk(OFF_RAW, 32'h05, 32'h1F);
      pin_chk({7'h0, port_irq}, 8'h01, 8'h01);
      wr(OFF_CLEAR, 32'h01);
      settle();
      reg_chk(OFF_RAW, 32'h04, 32'h1F);
      pin_chk({7'h0, port_irq}, 8'h00, 8'h01);
      ext_level <= 8'h12;
      settle();
      ext_level <= 8'h10;
      settle();
      reg_chk(OFF_RAW, 32'h06, 32'h1F);
      wr(OFF_MASK, 32'h02);
      settle();
      pin_chk({7'h0, port_irq}, 8'h01, 8'h01);

      // pad controls and open drain
      wr(OFF_PULL_DOWN, 32'h01);
      wr(OFF_DRV8, 32'h02);
      wr(OFF_SLEW, 32'h02);
      wr(OFF_OPEN_DRAIN, 32'h04);
      wr(OFF_DIR, 32'h04);
      wr(12'h010, 32'h04);
      settle();
      pin_chk(pad_cfg.pull_down, 8'h01, 8'hBF);
      pin_chk(pad_cfg.drive_8ma, 8'h02, 8'hBF);
      pin_chk(pad_cfg.drive_2ma, 8'hFD, 8'hBF);
      pin_chk(pad_cfg.slew, 8'h02, 8'hBF);
      pin_chk(pad_cfg.open_drain, 8'h04, 8'hBF);
      pin_chk(pad_oe, 8'h00, 8'h04);
      close_out();
   end
endmodule
`default_nettype wire
